/* logic/vclw_pkg.sv */
// Constants shared by the video capture line writer
package vclw_pkg;
   localparam int SEG_BYTES = 128;
   localparam int SEG_SHIFT = 7;
   localparam int ADDR_W = 32;
   localparam int LEN_W = 16;
   localparam int DATA_W = 64;
   localparam int BYTES_PER_BEAT = 8;
   localparam int FIFO_DEPTH = 32;
   localparam logic [0:0] CLIENT_LUMA = 1'h0;
   localparam logic [0:0] CLIENT_CHROMA = 1'h1;
   typedef enum logic [1:0] {
      VCLW_IDLE = 2'b00,
      VCLW_SEG = 2'b01,
      VCLW_REM = 2'b10,
      VCLW_WAIT = 2'b11
   } vclw_state_type;
endpackage

/* logic/vclw_fifo.sv */
// Parameterised valid/ready FIFO for the capture data path
`timescale 1ns/1ps
module vclw_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("vclw_fifo depth must be a power of two");
      end
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic push, pop;
   // Full when pointers differ only in the wrap bit
   always_comb begin
      in_ready = !((wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
      out_valid = (wr_ff != rd_ff);
      out_data = mem[rd_ff[AW-1:0]];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
      nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
   end
   // Storage has no reset; only written words are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ff[AW-1:0]] <= in_data;
      end
   end
endmodule

/* logic/vclw_writer.sv */
// Video capture line writer: segments lines into DDR write bursts
`timescale 1ns/1ps
// How it works
// [R1] Full 128-byte segments go out as bursts.
// [R2] Line end sends leftover bytes as one burst.
// [R3] Line start address steps by stride afterwards.
// [R4] Remainder always taken from the current line.
// [R5] Two remainder slots per client, ping-ponged.
// [R6] Reset or abort clears client remainders to zero.
// [R7] Luma and chroma tracked by separate clients.
// [R8] 420 mode drops every second chroma line.
// [R9] Same handling for one-line and multichannel frames.
// [R10] Source should avoid one-line multichannel frames.
// [R11] Never issue a zero-length burst.
module vclw_writer
   import vclw_pkg::*;
#(
   parameter int STRIDE_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic abort_luma,
   input wire logic abort_chroma,
   input wire logic chroma_420_en,
   input wire logic [vclw_pkg::ADDR_W-1:0] luma_base,
   input wire logic [vclw_pkg::ADDR_W-1:0] chroma_base,
   input wire logic [STRIDE_W-1:0] line_stride,
   // Captured line stream from the video input port
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [vclw_pkg::DATA_W-1:0] in_data,
   input wire logic in_client,
   input wire logic in_sof,
   input wire logic in_eol,
   // DDR write command
   output logic cmd_valid_ff,
   input wire logic cmd_ready,
   output logic [vclw_pkg::ADDR_W-1:0] cmd_addr_ff,
   output logic [vclw_pkg::LEN_W-1:0] cmd_len_ff,
   output logic cmd_client_ff,
   // DDR write data
   output logic wdata_valid,
   input wire logic wdata_ready,
   output logic [vclw_pkg::DATA_W-1:0] wdata
);
   import vclw_pkg::*;
   initial begin
      if (STRIDE_W > ADDR_W) begin
         $error("vclw_writer stride wider than address");
      end
   end

   // Byte counters, line addresses and remainder slots per client
   logic [LEN_W-1:0] seg_cnt_ff [2];
   logic [LEN_W-1:0] nxt_seg_cnt [2];
   logic [ADDR_W-1:0] line_addr_ff [2];
   logic [ADDR_W-1:0] nxt_line_addr [2];
   logic [ADDR_W-1:0] off_ff [2];
   logic [ADDR_W-1:0] nxt_off [2];
   logic [LEN_W-1:0] rem_ff [2][2];
   logic [LEN_W-1:0] nxt_rem [2][2];
   logic [1:0] pp_ff, nxt_pp;
   logic chroma_skip_ff, nxt_chroma_skip;
   logic nxt_cmd_valid, nxt_cmd_client;
   logic [ADDR_W-1:0] nxt_cmd_addr;
   logic [LEN_W-1:0] nxt_cmd_len;
   logic beat, drop, keep;
   logic [LEN_W-1:0] cnt_after;
   logic [LEN_W-1:0] seg_full;
   logic [0:0] c;
   logic fifo_ready;
   logic in_ready_core;

   // Dropped chroma lines bypass the FIFO entirely
   vclw_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(in_valid && keep && in_ready_core),
      .in_ready(fifo_ready),
      .in_data(in_data),
      .out_valid(wdata_valid),
      .out_ready(wdata_ready),
      .out_data(wdata)
   );

   // Input stalls while a command waits, and when the FIFO is full unless the beat is a dropped chroma beat
   always_comb begin
      c = in_client;
      seg_full = LEN_W'(SEG_BYTES);
      drop = (c == CLIENT_CHROMA) && chroma_420_en && chroma_skip_ff; // [R8]
      keep = !drop;
      in_ready_core = !cmd_valid_ff;
      in_ready = in_ready_core && (fifo_ready || drop);
      beat = in_valid && in_ready;
      cnt_after = seg_cnt_ff[c] + LEN_W'(BYTES_PER_BEAT);
   end

   // Segment, remainder and stride sequencing
   always_comb begin
      nxt_seg_cnt = seg_cnt_ff;
      nxt_line_addr = line_addr_ff;
      nxt_off = off_ff;
      nxt_rem = rem_ff;
      nxt_pp = pp_ff;
      nxt_chroma_skip = chroma_skip_ff;
      nxt_cmd_valid = cmd_valid_ff && !cmd_ready;
      nxt_cmd_addr = cmd_addr_ff;
      nxt_cmd_len = cmd_len_ff;
      nxt_cmd_client = cmd_client_ff;
      if (beat && in_sof) begin
         // Frame start reloads base; stale remainders are not reused
         nxt_line_addr[c] = (c == CLIENT_LUMA) ? luma_base : chroma_base;
         nxt_off[c] = '0;
         if (c == CLIENT_CHROMA) begin
            nxt_chroma_skip = 1'b0;
         end
      end
      if (beat && keep) begin // [R7]
         nxt_seg_cnt[c] = cnt_after;
         if (cnt_after == seg_full) begin // [R1]
            nxt_cmd_valid = 1'b1;
            nxt_cmd_addr = (in_sof ? ((c == CLIENT_LUMA) ? luma_base : chroma_base)
                            : line_addr_ff[c]) + (in_sof ? '0 : off_ff[c]);
            nxt_cmd_len = seg_full;
            nxt_cmd_client = c;
            nxt_off[c] = (in_sof ? '0 : off_ff[c]) + ADDR_W'(SEG_BYTES);
            nxt_seg_cnt[c] = '0;
         end
         if (in_eol) begin
            // Remainder computed from this line's own count [R4] [R9]
            nxt_rem[c][pp_ff[c]] = (cnt_after == seg_full) ? '0 : cnt_after; // [R2] [R5]
            nxt_pp[c] = ~pp_ff[c]; // [R5]
            if (cnt_after != seg_full) begin // [R11]
               nxt_cmd_valid = 1'b1;
               nxt_cmd_addr = (in_sof ? ((c == CLIENT_LUMA) ? luma_base : chroma_base)
                               : line_addr_ff[c]) + (in_sof ? '0 : off_ff[c]);
               nxt_cmd_len = cnt_after; // [R2]
               nxt_cmd_client = c;
            end
            nxt_seg_cnt[c] = '0;
            nxt_off[c] = '0;
            nxt_line_addr[c] = (in_sof ? ((c == CLIENT_LUMA) ? luma_base : chroma_base)
                                : line_addr_ff[c]) + ADDR_W'(line_stride); // [R3]
         end
      end
      if (beat && in_eol && c == CLIENT_CHROMA && chroma_420_en) begin
         nxt_chroma_skip = ~chroma_skip_ff; // [R8]
      end
      // Abort clears that client's slots, byte count and offset; beats already in the FIFO still go out
      if (abort_luma) begin // [R6]
         nxt_rem[CLIENT_LUMA] = '{default: '0};
         nxt_pp[CLIENT_LUMA] = 1'b0;
         nxt_seg_cnt[CLIENT_LUMA] = '0;
         nxt_off[CLIENT_LUMA] = '0;
      end
      if (abort_chroma) begin // [R6]
         nxt_rem[CLIENT_CHROMA] = '{default: '0};
         nxt_pp[CLIENT_CHROMA] = 1'b0;
         nxt_seg_cnt[CLIENT_CHROMA] = '0;
         nxt_off[CLIENT_CHROMA] = '0;
         nxt_chroma_skip = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seg_cnt_ff <= '{default: '0};
         line_addr_ff <= '{default: '0};
         off_ff <= '{default: '0};
         rem_ff <= '{default: '{default: '0}}; // [R6]
         pp_ff <= '0;
         chroma_skip_ff <= 1'b0;
         cmd_valid_ff <= 1'b0;
         cmd_addr_ff <= '0;
         cmd_len_ff <= '0;
         cmd_client_ff <= 1'b0;
      end else begin
         seg_cnt_ff <= nxt_seg_cnt;
         line_addr_ff <= nxt_line_addr;
         off_ff <= nxt_off;
         rem_ff <= nxt_rem;
         pp_ff <= nxt_pp;
         chroma_skip_ff <= nxt_chroma_skip;
         cmd_valid_ff <= nxt_cmd_valid;
         cmd_addr_ff <= nxt_cmd_addr;
         cmd_len_ff <= nxt_cmd_len;
         cmd_client_ff <= nxt_cmd_client;
      end
   end
endmodule

/* test/vclw_monitor.sv */
// Checker for the line writer command and data ports
`timescale 1ns/1ps
module vclw_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Stream and DDR side
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic cmd_valid_ff,
   input wire logic cmd_ready,
   input wire logic [15:0] cmd_len_ff,
   input wire logic [31:0] cmd_addr_ff,
   input wire logic wdata_valid,
   input wire logic wdata_ready,
   input wire logic [63:0] wdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence beat_s; in_valid && in_ready; endsequence
   sequence wait_s; cmd_valid_ff && !cmd_ready; endsequence
   // Burst lengths: never empty, at most one segment, whole beats
   chk_len_nonzero: assert property (cmd_valid_ff |-> cmd_len_ff != 16'h0)
      else $error("zero length burst");
   chk_len_bound: assert property (cmd_valid_ff |-> cmd_len_ff <= 16'h80)
      else $error("burst over one segment");
   chk_len_align: assert property (cmd_valid_ff |-> cmd_len_ff[2:0] == 3'h0)
      else $error("burst not whole beats");
   // A stalled command keeps its length and address
   chk_cmd_hold: assert property (wait_s |=> cmd_valid_ff && $stable(cmd_len_ff)
      && $stable(cmd_addr_ff)) else $error("command changed while stalled");
   chk_in_block: assert property (cmd_valid_ff |-> !in_ready)
      else $error("beat taken while command pending");
   chk_one_pend: assert property (cmd_valid_ff && cmd_ready |=> !cmd_valid_ff)
      else $error("second command without a beat");
   // Commands arise only from a beat one cycle earlier
   chk_cmd_cause: assert property ($rose(cmd_valid_ff) |-> $past(in_valid && in_ready))
      else $error("command without a beat");
   chk_data_hold: assert property (wdata_valid && !wdata_ready |=> wdata_valid
      && $stable(wdata)) else $error("data changed while stalled");
   cov_beat: cover property (beat_s ##1 beat_s);
endmodule
bind vclw_writer vclw_monitor u_mon (.clk, .rst_n, .in_valid, .in_ready, .cmd_valid_ff,
   .cmd_ready, .cmd_len_ff, .cmd_addr_ff, .wdata_valid, .wdata_ready, .wdata);

/* test/vclw_ddr_model.sv */
// Behavioural DDR interconnect model with periodic and forced stalls
`timescale 1ns/1ps
module vclw_ddr_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Long data stall from the bench
   input wire logic slow,
   // Ready outputs
   output logic cmd_ready,
   output logic wdata_ready
);
   logic [1:0] cnt_ff;
   // Free-running count; stalls never depend on what is offered
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_ff <= 2'h0;
      else cnt_ff <= cnt_ff + 2'h1;
   end
   assign cmd_ready = cnt_ff[0];
   assign wdata_ready = !slow && cnt_ff != 2'h3;
endmodule

/* test/tb_vclw_writer.sv */
// Self-checking bench for the line writer
`timescale 1ns/1ps
module tb_vclw_writer;
   logic clk = 0, rst_n = 0, ab_l = 0, c420 = 0, slow = 0, full = 0;
   logic in_valid = 0, in_client = 0, in_sof = 0, in_eol = 0;
   logic [63:0] in_data = 0, dn = 0, wdata;
   logic in_ready, cmd_valid_ff, cmd_ready, cmd_client_ff, wdata_valid, wdata_ready;
   logic [31:0] cmd_addr_ff;
   logic [15:0] cmd_len_ff;
   logic [48:0] qc[$];
   logic [63:0] qd[$], xd[$];
   int err_count = 0, cmp_count = 0;
   vclw_writer DUT (.clk, .rst_n, .abort_luma(ab_l), .abort_chroma(1'b0), .chroma_420_en(c420),
      .luma_base(32'h1000), .chroma_base(32'h8000), .line_stride(16'h100), .in_valid,
      .in_ready, .in_data, .in_client, .in_sof, .in_eol, .cmd_valid_ff, .cmd_ready,
      .cmd_addr_ff, .cmd_len_ff, .cmd_client_ff, .wdata_valid, .wdata_ready, .wdata);
   vclw_ddr_model u_ddr (.clk, .rst_n, .slow, .cmd_ready, .wdata_ready);
   initial forever #25 clk = ~clk;
   // Record accepted commands, data, and refusals with no command pending
   always @(posedge clk) begin
      if (cmd_valid_ff && cmd_ready) qc.push_back({cmd_client_ff, cmd_len_ff, cmd_addr_ff});
      if (wdata_valid && wdata_ready) qd.push_back(wdata);
      if (in_valid && !in_ready && !cmd_valid_ff) full <= 1;
   end
   task chk(logic [63:0] v, e);
      cmp_count++;
      if (v !== e) begin
         err_count++;
         $display("[FAIL] %0t seen %h want %h", $time, v, e);
      end
   endtask
   // One beat, called 1 ns after an edge; held until in_ready stands at an edge
   task beat(logic c, s, e);
      logic took;
      {in_valid, in_client, in_sof, in_eol, in_data} = {1'b1, c, s, e, dn};
      if (!c) xd.push_back(dn);
      dn++;
      took = 0;
      // in_ready is settled mid-cycle, so the edge that follows takes the beat
      while (!took) begin
         @(negedge clk);
         took = (in_ready === 1'b1);
         @(posedge clk);
         #1;
      end
   endtask
   // Source side; one-line frames are still sent to prove the writer copes
   task line(logic c, s, int n);
      for (int i = 0; i < n; i++) beat(c, s && i == 0, i == n - 1);
   endtask
   task expc(logic [48:0] e);
      in_valid = 0;
      for (int i = 0; i < 400 && qc.size() == 0; i++) #50;
      chk(qc.size() ? qc.pop_front() : 49'h0, e);
   endtask
   task quiet;
      repeat (40) #50;
      chk(qc.size(), 0);
   endtask
   task t_seg;
      line(0, 1, 19);
      line(0, 0, 16);
      expc({1'b0, 16'h80, 32'h1000});
      expc({1'b0, 16'h18, 32'h1080});
      expc({1'b0, 16'h80, 32'h1100});
      quiet;
      line(0, 1, 3);
      expc({1'b0, 16'h18, 32'h1000});
      rst_n = 0;
      #1000 rst_n = 1;
      line(0, 1, 2);
      expc({1'b0, 16'h10, 32'h1000});
      $display("t_seg done");
   endtask
   task t_abort;
      line(0, 1, 5);
      expc({1'b0, 16'h28, 32'h1000});
      ab_l = 1;
      #50 ab_l = 0;
      line(0, 1, 1);
      expc({1'b0, 16'h8, 32'h1000});
      $display("t_abort done");
   endtask
   task t_chroma;
      c420 = 1;
      line(1, 1, 4);
      line(0, 1, 1);
      line(1, 0, 4);
      expc({1'b1, 16'h20, 32'h8000});
      expc({1'b0, 16'h8, 32'h1000});
      quiet;
      c420 = 0;
      $display("t_chroma done");
   endtask
   task t_fifo;
      slow = 1;
      qd.delete();
      xd.delete();
      fork
         repeat (3) line(0, 1, 16);
         #3000 slow = 0;
      join
      in_valid = 0;
      for (int i = 0; i < 400 && qd.size() < 48; i++) #50;
      chk(full, 1);
      chk(qc.size(), 3);
      chk(qd.size(), 48);
      foreach (xd[i]) chk(qd[i], xd[i]);
      $display("t_fifo done");
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #1 rst_n = 1;
      t_seg;
      t_abort;
      t_chroma;
      t_fifo;
      close_out;
   end
   initial begin
      #3000000 err_count++;
      close_out;
   end
endmodule
